// ---- olpa_params.svh ----
// olpa_params.svh: offsets, field positions, reset values and timing counts
// assumes a 100 MHz ref_clk; included by both ends of the access-control link
`ifndef OLPA_PARAMS_SVH
`define OLPA_PARAMS_SVH

// ---------------------------------------------------------------------------
// otp space map
// ---------------------------------------------------------------------------
`define OLPA_SN_LOCK_ADDR     10'h100
`define OLPA_FSN_FIRST        10'h102
`define OLPA_FSN_LAST         10'h109
`define OLPA_LOW_LOCK0_ADDR   10'h112
`define OLPA_LOW_LOCK1_ADDR   10'h113
`define OLPA_REGION1_BASE     10'h114
`define OLPA_UP_LOCK_LO_ADDR  10'h214
`define OLPA_UP_LOCK_HI_ADDR  10'h215
`define OLPA_REGION17_BASE    10'h216
`define OLPA_TOP_FIRST        10'h2F6
`define OLPA_TOP_LAST         10'h2FF
`define OLPA_REGION_BYTES     16
`define OLPA_TOP_BYTES        10

// ---------------------------------------------------------------------------
// programmable-bit masks and delivered contents
// ---------------------------------------------------------------------------
`define OLPA_SN_LOCK_PGM_MASK 8'h03
`define OLPA_UP_HI_PGM_MASK   8'h7F
`define OLPA_SN_LOCK_RESET    8'h01
`define OLPA_ERASED_BYTE      8'hFF
`define OLPA_STATUS_RESET     8'h00
`define OLPA_CONFIG_RESET     8'h00
`define OLPA_FSN_DEFAULT      64'h0123_4567_89AB_CDEF

// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define OLPA_CLK_MHZ          100
`define OLPA_POWER_UP_US      300
`define OLPA_ACCEL_SETTLE_US  5
`define OLPA_POWER_UP_CYC     (`OLPA_POWER_UP_US * `OLPA_CLK_MHZ)
`define OLPA_ACCEL_SETTLE_CYC (`OLPA_ACCEL_SETTLE_US * `OLPA_CLK_MHZ)

`endif

// ---- olpa_pkg.sv ----
// olpa_pkg.sv: types shared by both ends of the otp access-control link
// assumes nothing beyond a SystemVerilog compiler
package olpa_pkg;

  // ---------------------------------------------------------------------------
  // command codes carried on the link (block-local encoding)
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OLPA_CMD_NONE     = 3'h0,
    OLPA_CMD_READ     = 3'h1,
    OLPA_CMD_READ_ST  = 3'h2,
    OLPA_CMD_PROGRAM  = 3'h3,
    OLPA_CMD_WREN     = 3'h4,
    OLPA_CMD_WR_REG   = 3'h5,
    OLPA_CMD_ERASE    = 3'h6
  } olpa_cmd_e;

  typedef logic [9:0] olpa_addr_t;
  typedef logic [7:0] olpa_byte_t;

endpackage

// ---- olpa_link_if.sv ----
// olpa_link_if.sv: command link between host controller and otp access end
// assumes both ends run on one ref_clk; one command per select pulse
`timescale 1ns/1ps
interface olpa_link_if
  import olpa_pkg::*;
();
  logic       sel_n;       // device select, active low, one cycle per command
  olpa_cmd_e  cmd;
  olpa_addr_t addr;
  olpa_byte_t wdata;
  logic       accel_hv;    // write_protect_accel_pin at accel_high_voltage
  logic       quad_mode;   // quad i/o mode, pin function disabled
  logic       supply_ok;   // supply above minimum operating level
  olpa_byte_t rdata;
  logic       rvalid;
  logic       ignored;     // command refused, one-cycle pulse

  modport device (input sel_n, cmd, addr, wdata, accel_hv, quad_mode, supply_ok,
                  output rdata, rvalid, ignored);
  modport host   (output sel_n, cmd, addr, wdata, accel_hv, quad_mode, supply_ok,
                  input rdata, rvalid, ignored);
endinterface

// ---- olpa_host.sv ----
// olpa_host.sv: host controller end; paces commands after power-up and accel
// assumes the user holds a request until req_ack; one request at a time
`timescale 1ns/1ps
`include "olpa_params.svh"
module olpa_host
  import olpa_pkg::*;
#(
  parameter int POWER_UP_CYC = `OLPA_POWER_UP_CYC,
  parameter int SETTLE_CYC   = `OLPA_ACCEL_SETTLE_CYC
) (
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   rst_n,
  // user side
  input  wire logic   supply_good,
  input  wire logic   accel_req,
  input  wire logic   quad_req,
  input  wire logic   req_valid,
  input  olpa_cmd_e   req_cmd,
  input  olpa_addr_t  req_addr,
  input  olpa_byte_t  req_wdata,
  output logic        req_ack,
  output logic        req_reject,
  output olpa_byte_t  rsp_data,
  output logic        rsp_valid,
  // link
  olpa_link_if.host   link
);
  initial begin
    if (POWER_UP_CYC < 1 || SETTLE_CYC < 1) $error("olpa_host: counts must be >= 1");
  end

  // ---------------------------------------------------------------------------
  // wait counter: power-up then each accel edge
  // ---------------------------------------------------------------------------
  logic [31:0] wait_reg;
  logic        accel_reg;
  logic        sel_n_reg;
  logic        ack_reg, rej_reg;
  olpa_cmd_e   cmd_reg;
  olpa_addr_t  addr_reg;
  olpa_byte_t  wdata_reg;
  olpa_byte_t  rsp_reg;
  logic        rspv_reg;
  logic        busy_reg;

  wire ready_w   = supply_good && (wait_reg == 32'h0) && !busy_reg;
  wire accel_chg = accel_req != accel_reg;
  // only status read and program while at high voltage outside quad mode; any command in quad mode
  wire cmd_ok_w  = !accel_reg || quad_req || req_cmd == OLPA_CMD_READ_ST ||
                   req_cmd == OLPA_CMD_PROGRAM;
  wire issue_w   = req_valid && ready_w && !accel_chg && cmd_ok_w;

  // counter reloads at power loss and at each accel change
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg  <= 32'h0;
      accel_reg <= 1'b0;
    end else begin
      accel_reg <= accel_req;
      if (!supply_good)
        wait_reg <= 32'(POWER_UP_CYC);
      else if (accel_chg)
        wait_reg <= 32'(SETTLE_CYC);
      else if (wait_reg != 32'h0)
        wait_reg <= wait_reg - 32'h1;
    end
  end

  // issue one command per select pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_n_reg <= 1'b1;
      cmd_reg   <= OLPA_CMD_NONE;
      addr_reg  <= 10'h000;
      wdata_reg <= 8'h00;
      ack_reg   <= 1'b0;
      rej_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      rsp_reg   <= 8'h00;
      rspv_reg  <= 1'b0;
    end else begin
      sel_n_reg <= !(issue_w && supply_good);
      ack_reg   <= issue_w;
      rej_reg   <= req_valid && ready_w && !accel_chg && !cmd_ok_w;
      if (issue_w) begin
        cmd_reg   <= req_cmd;
        addr_reg  <= req_addr;
        wdata_reg <= req_wdata;
      end
      busy_reg  <= issue_w;
      rspv_reg  <= link.rvalid;
      if (link.rvalid) rsp_reg <= link.rdata;
    end
  end

  assign link.sel_n     = sel_n_reg;
  assign link.cmd       = cmd_reg;
  assign link.addr      = addr_reg;
  assign link.wdata     = wdata_reg;
  assign link.accel_hv  = accel_reg;
  assign link.quad_mode = quad_req;
  assign link.supply_ok = supply_good;
  assign req_ack        = ack_reg;
  assign req_reject     = rej_reg;
  assign rsp_data       = rsp_reg;
  assign rsp_valid      = rspv_reg;
endmodule

// ---- olpa_device.sv ----
// olpa_device.sv: otp lock and power-up access control of the flash end
// assumes the host paces commands; rst_n is the power-on state
// How it works
// - serial lock bit0/bit1 guard the two serial regions
// - serial lock bits 2..7 cannot be programmed
// - upper lock high bit7 fixed, bits 0..6 lock
// - power-up: standby, write enable latch cleared
// - host waits power-up delay after an edge with supply low; reset loads none
// - host drives select high from the first edge with supply not ready
// - supply below minimum: every command ignored
// - delivered: array all ones, status/config zero
// - delivered: serial lock 0x01, factory serial filled
// - host waits settle delay after accel change
// - at high voltage only status read, program
// - quad mode disables accel pin function
// - top region 10 bytes, others 16 bytes
// - lower lock bytes lock regions one to sixteen
`timescale 1ns/1ps
`include "olpa_params.svh"
module olpa_device
  import olpa_pkg::*;
#(
  parameter logic [63:0] FSN_VALUE = `OLPA_FSN_DEFAULT  // arbitrary stand-in value
) (
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   rst_n,
  // state seen by the user
  output logic        write_enable_latch,
  output logic        deep_power_down,
  output logic        accel_active,
  output olpa_byte_t  status_byte,
  // link
  olpa_link_if.device link
);
  // ---------------------------------------------------------------------------
  // otp storage and lock state
  // ---------------------------------------------------------------------------
  localparam int OTP_BYTES = 1024;
  olpa_byte_t otp_mem [OTP_BYTES];
  olpa_byte_t rdata_reg;
  logic       rvalid_reg, ign_reg, wel_reg;
  olpa_byte_t status_reg;
  olpa_byte_t config_reg;

  // lock bytes read straight from the space; a cleared (programmed) bit locks
  wire olpa_byte_t sn_lock = otp_mem[`OLPA_SN_LOCK_ADDR];
  wire olpa_byte_t lo0     = otp_mem[`OLPA_LOW_LOCK0_ADDR];
  wire olpa_byte_t lo1     = otp_mem[`OLPA_LOW_LOCK1_ADDR];
  wire olpa_byte_t up_lo   = otp_mem[`OLPA_UP_LOCK_LO_ADDR];
  wire olpa_byte_t up_hi   = otp_mem[`OLPA_UP_LOCK_HI_ADDR];
  wire [30:0] region_lock  = ~{up_hi[6:0], up_lo, lo1, lo0};

  // region index of the address: 0 none, 1..31 numbered region
  logic [4:0] region_idx;
  always_comb begin
    region_idx = 5'h00;
    if (link.addr >= `OLPA_TOP_FIRST && link.addr <= `OLPA_TOP_LAST)
      region_idx = 5'h1F;
    else if (link.addr >= `OLPA_REGION17_BASE && link.addr < `OLPA_TOP_FIRST)
      region_idx = 5'(((link.addr - `OLPA_REGION17_BASE) >> 4) + 17);
    else if (link.addr >= `OLPA_REGION1_BASE && link.addr < `OLPA_UP_LOCK_LO_ADDR)
      region_idx = 5'(((link.addr - `OLPA_REGION1_BASE) >> 4) + 1);
  end

  wire in_fsn  = link.addr >= `OLPA_FSN_FIRST && link.addr <= `OLPA_FSN_LAST;
  wire in_sn2  = link.addr >  `OLPA_FSN_LAST  && link.addr <  `OLPA_LOW_LOCK0_ADDR;
  wire locked  = (in_fsn && !sn_lock[0]) || (in_sn2 && !sn_lock[1]) ||
                 (region_idx != 5'h00 && region_lock[region_idx - 5'h01]);

  // program mask: fixed bits of lock bytes never change
  wire olpa_byte_t pgm_mask =
    (link.addr == `OLPA_SN_LOCK_ADDR)    ? `OLPA_SN_LOCK_PGM_MASK :
    (link.addr == `OLPA_UP_LOCK_HI_ADDR) ? `OLPA_UP_HI_PGM_MASK  :
                                            8'hFF;

  // accel pin acts only outside quad mode
  wire accel_w  = link.accel_hv && !link.quad_mode;
  wire take_w   = !link.sel_n && link.supply_ok;
  wire cmd_ok   = !accel_w || link.cmd == OLPA_CMD_READ_ST || link.cmd == OLPA_CMD_PROGRAM;
  wire do_pgm   = take_w && cmd_ok && link.cmd == OLPA_CMD_PROGRAM &&
                  wel_reg && !locked;
  wire olpa_byte_t new_byte = otp_mem[link.addr] & (~pgm_mask | link.wdata); // only clears bits

  // storage: delivered contents at power-on, programs clear bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < OTP_BYTES; i++)
        otp_mem[i] <= `OLPA_ERASED_BYTE;
      otp_mem[`OLPA_SN_LOCK_ADDR] <= `OLPA_SN_LOCK_RESET;
      for (int b = 0; b < 8; b++)
        otp_mem[`OLPA_FSN_FIRST + b] <= FSN_VALUE[8*b +: 8];
    end else if (do_pgm) begin
      otp_mem[link.addr] <= new_byte;
    end
  end

  // ---------------------------------------------------------------------------
  // command handling, status and answers
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_reg    <= 1'b0;
      status_reg <= `OLPA_STATUS_RESET;
      config_reg <= `OLPA_CONFIG_RESET;
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
      ign_reg    <= 1'b0;
    end else begin
      rvalid_reg <= 1'b0;
      ign_reg    <= !link.sel_n && !(link.supply_ok && cmd_ok);
      if (!link.supply_ok) wel_reg <= 1'b0;
      else if (take_w && cmd_ok) begin
        case (link.cmd)
          OLPA_CMD_WREN:    wel_reg <= 1'b1;
          OLPA_CMD_PROGRAM: wel_reg <= 1'b0;
          OLPA_CMD_WR_REG: begin
            if (wel_reg) config_reg <= link.wdata;
            wel_reg <= 1'b0;
          end
          OLPA_CMD_READ: begin
            rdata_reg  <= otp_mem[link.addr];
            rvalid_reg <= 1'b1;
          end
          OLPA_CMD_READ_ST: begin
            rdata_reg  <= {status_reg[7:2], wel_reg, 1'b0};
            rvalid_reg <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // status mirrors write enable latch in bit 1
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0;
      deep_power_down    <= 1'b0;
      accel_active       <= 1'b0;
      status_byte        <= `OLPA_STATUS_RESET;
    end else begin
      write_enable_latch <= wel_reg;
      deep_power_down    <= 1'b0;
      accel_active       <= accel_w;
      status_byte        <= {status_reg[7:2], wel_reg, 1'b0};
    end
  end

  assign link.rdata  = rdata_reg;
  assign link.rvalid = rvalid_reg;
  assign link.ignored = ign_reg;
endmodule

// ---- olpa_props.sv ----
// olpa_props.sv: assertions on the link between host end and otp end
// assumes plain copies of the olpa_link_if signals and the shared clock
`timescale 1ns/1ps
module olpa_props
  import olpa_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link
  input wire logic sel_n,
  input olpa_cmd_e cmd,
  input olpa_addr_t addr,
  input wire logic accel_hv,
  input wire logic quad_mode,
  input wire logic supply_ok,
  input olpa_byte_t rdata,
  input wire logic rvalid,
  input wire logic ignored
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------------------
  // taken commands
  // ---------------------------------------------------------------------------
  wire gate_on = accel_hv && !quad_mode;
  wire hv_legal = (cmd == OLPA_CMD_READ_ST) || (cmd == OLPA_CMD_PROGRAM);
  wire taken = !sel_n && supply_ok;
  sequence s_read(a);
    taken && !gate_on && cmd == OLPA_CMD_READ && addr == a;
  endsequence
  sequence s_hv_cmd;
    taken && gate_on;
  endsequence
  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_low_supply: assert property (!sel_n && !supply_ok |=> ignored && !rvalid)
    else $error("command answered while supply low");
  a_hv_refuse: assert property (s_hv_cmd ##0 !hv_legal |=> ignored)
    else $error("illegal command not refused at high voltage");
  a_hv_status: assert property (s_hv_cmd ##0 cmd == OLPA_CMD_READ_ST |=> rvalid && !ignored)
    else $error("status read refused at high voltage");
  a_quad_free: assert property (taken && quad_mode && cmd == OLPA_CMD_READ |=> rvalid)
    else $error("read refused in quad mode");
  a_sn_fixed: assert property (s_read(10'h100) |=> rvalid && rdata[7:2] == 6'h00)
    else $error("serial lock high bits changed");
  a_up_bit7: assert property (s_read(10'h215) |=> rvalid && rdata[7])
    else $error("upper lock bit7 programmed");
  a_top_read: assert property (s_read(10'h2FF) |=> rvalid && !ignored)
    else $error("top region end not readable");
  a_answer_cause: assert property (rvalid |-> $past(taken))
    else $error("read answer without taken command");
  // select is registered: a supply drop reaches sel_n one edge later
  a_sel_supply: assert property (!supply_ok |=> sel_n)
    else $error("select asserted while supply not ready");
endmodule

// ---- otp_lock_powerup_accel_gating_tb.sv ----
// otp_lock_powerup_accel_gating_tb.sv: self-checking bench for both ends
// assumes olpa_params.svh, olpa_pkg, olpa_link_if, olpa_host, olpa_device
`timescale 1ns/1ps
`include "olpa_params.svh"
module otp_lock_powerup_accel_gating_tb;
  import olpa_pkg::*;
  localparam int PU = 20;
  localparam int ST = 5;
  localparam logic [63:0] FSN = `OLPA_FSN_DEFAULT;
  logic       ref_clk, rst_n, supply_good, accel_req, quad_req, req_valid;
  logic       req_ack, req_reject, rsp_valid;
  logic       write_enable_latch, deep_power_down, accel_active;
  olpa_cmd_e  req_cmd;
  olpa_addr_t req_addr;
  olpa_byte_t req_wdata, rsp_data, status_byte, q;
  logic       rej;
  int         n, total_checks, n_mismatch;
  olpa_link_if link();
  olpa_host #(.POWER_UP_CYC(PU), .SETTLE_CYC(ST)) i_olpa_host (.ref_clk, .rst_n,
    .supply_good, .accel_req, .quad_req, .req_valid, .req_cmd, .req_addr, .req_wdata,
    .req_ack, .req_reject, .rsp_data, .rsp_valid, .link(link.host));
  olpa_device i_olpa_device (.ref_clk, .rst_n, .write_enable_latch, .deep_power_down,
    .accel_active, .status_byte, .link(link.device));
  olpa_props i_olpa_props (.ref_clk, .rst_n, .sel_n(link.sel_n), .cmd(link.cmd),
    .addr(link.addr), .accel_hv(link.accel_hv), .quad_mode(link.quad_mode),
    .supply_ok(link.supply_ok), .rdata(link.rdata), .rvalid(link.rvalid),
    .ignored(link.ignored));
  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one request held until ack or reject, then the answer of a read
  task automatic req(input olpa_cmd_e c, input olpa_addr_t a, input olpa_byte_t d);
    n = 0;
    q = 8'h00;
    req_cmd = c;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (req_ack !== 1'b1 && req_reject !== 1'b1 && n < 400);
    rej = req_reject;
    req_valid = 1'b0;
    if (n >= 400) check(8'h01, 8'h00);
    if (!rej && (c == OLPA_CMD_READ || c == OLPA_CMD_READ_ST)) begin
      for (int i = 0; i < 8 && rsp_valid !== 1'b1; i++) begin
        @(posedge ref_clk);
        #1;
      end
      q = rsp_data;
    end
    @(posedge ref_clk);
    #1;
  endtask
  task automatic prog(input olpa_addr_t a, input olpa_byte_t d);
    req(OLPA_CMD_WREN, 10'h000, 8'h00);
    req(OLPA_CMD_PROGRAM, a, d);
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  // one edge with supply low loads the power-up wait, then the first command
  task automatic t_power_up();
    check(write_enable_latch, 1'b0);
    check(deep_power_down, 1'b0);
    @(posedge ref_clk);
    #1;
    supply_good = 1'b1;
    req(OLPA_CMD_READ_ST, 10'h000, 8'h00);
    check(n >= PU, 1'b1);
    check(q, 8'h00);
    check(status_byte, 8'h00);
  endtask
  task automatic t_delivered();
    req(OLPA_CMD_READ, 10'h100, 8'h00);
    check(q, 8'h01);
    for (int i = 0; i < 8; i++) begin
      req(OLPA_CMD_READ, 10'h102 + 10'(i), 8'h00);
      check(q, FSN[8*i +: 8]);
    end
    req(OLPA_CMD_READ, 10'h2FF, 8'h00);
    check(q, 8'hFF);
  endtask
  // a cleared lock bit locks: second serial region is locked as delivered
  task automatic t_locks();
    prog(10'h10A, 8'h3C);
    req(OLPA_CMD_READ, 10'h10A, 8'h00);
    check(q, 8'hFF);
    prog(10'h100, 8'h00);
    req(OLPA_CMD_READ, 10'h100, 8'h00);
    check(q, 8'h00);
    prog(10'h102, 8'h00);
    req(OLPA_CMD_READ, 10'h102, 8'h00);
    check(q, FSN[7:0]);
    prog(10'h133, 8'h5A);
    prog(10'h112, 8'hFE);
    prog(10'h123, 8'h00);
    req(OLPA_CMD_READ, 10'h123, 8'h00);
    check(q, 8'hFF);
    prog(10'h114, 8'h00);
    req(OLPA_CMD_READ, 10'h114, 8'h00);
    check(q, 8'hFF);
    req(OLPA_CMD_READ, 10'h133, 8'h00);
    check(q, 8'h5A);
    prog(10'h215, 8'h00);
    req(OLPA_CMD_READ, 10'h215, 8'h00);
    check(q, 8'h80);
    prog(10'h2FF, 8'h00);
    req(OLPA_CMD_READ, 10'h2FF, 8'h00);
    check(q, 8'hFF);
  endtask
  task automatic t_accel();
    accel_req = 1'b1;
    req(OLPA_CMD_READ, 10'h133, 8'h00);
    check(n >= ST, 1'b1);
    check(rej, 1'b1);
    check(accel_active, 1'b1);
    req(OLPA_CMD_READ_ST, 10'h000, 8'h00);
    check(rej, 1'b0);
    check(q, 8'h00);
    quad_req = 1'b1;
    req(OLPA_CMD_READ, 10'h133, 8'h00);
    check(rej, 1'b0);
    check(q, 8'h5A);
    check(accel_active, 1'b0);
    accel_req = 1'b0;
    quad_req = 1'b0;
    req(OLPA_CMD_READ, 10'h133, 8'h00);
    check(n >= ST, 1'b1);
    check(q, 8'h5A);
  endtask
  // supply drops just after a select: the command and the latch are dropped
  task automatic t_supply_drop();
    req(OLPA_CMD_WREN, 10'h000, 8'h00);
    req_cmd = OLPA_CMD_READ;
    req_addr = 10'h100;
    req_valid = 1'b1;
    for (int i = 0; i < 4 && req_ack !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check(req_ack, 1'b1);
    req_valid = 1'b0;
    supply_good = 1'b0;
    @(posedge ref_clk);
    #1;
    check(link.ignored, 1'b1);
    @(posedge ref_clk);
    #1;
    check(rsp_valid, 1'b0);
    check(write_enable_latch, 1'b0);
    supply_good = 1'b1;
    req(OLPA_CMD_READ_ST, 10'h000, 8'h00);
    check(n >= PU, 1'b1);
    check(q, 8'h00);
  endtask
  // ---------------------------------------------------------------------------
  // clock, sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    {rst_n, accel_req, quad_req, req_valid} = 4'h0;
    supply_good = 1'b0;
    req_cmd = OLPA_CMD_NONE;
    req_addr = 10'h000;
    req_wdata = 8'h00;
    total_checks = 0;
    n_mismatch = 0;
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_power_up();
    t_delivered();
    t_locks();
    t_accel();
    t_supply_drop();
    finish_test();
  end
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
endmodule
